// >>> acfg_top.sv
// Audio port configuration registers and the serial slot logic they steer
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module acfg_top #(
  parameter int MASTER_HALF_DIV = 4,
  parameter int FRAME_BITS = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire acfg_pkg::acfg_bus_req_t bus_req,
  output logic [acfg_pkg::DATA_W-1:0] rd_data,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic fsync_in,
  output logic fsync_out,
  output logic fsync_oe,
  input wire logic sdi_in,
  output logic serial_audio_out_pin,
  output logic serial_audio_out_pin_oe,
  input wire logic [15:0] adc_sample,
  input wire logic adc_valid,
  output logic [15:0] dac_sample,
  output logic dac_valid,
  output acfg_pkg::acfg_iface_cfg_t iface_cfg,
  output acfg_pkg::acfg_det_cfg_t det_cfg
);
  import acfg_pkg::*;

  // Refuse settings the counters cannot serve
  initial
  begin
    if (MASTER_HALF_DIV < 1 || MASTER_HALF_DIV > 255)
      $error("acfg_top: MASTER_HALF_DIV out of range");
    if (FRAME_BITS < 2 * SLOT_BITS || FRAME_BITS > 64)
      $error("acfg_top: FRAME_BITS out of range");
  end

  localparam logic [7:0] HALF_DIV_M1 = 8'(MASTER_HALF_DIV - 1);
  localparam logic [5:0] FRAME_LAST = 6'(FRAME_BITS - 1);
  localparam logic [5:0] SLOT0_LAST = 6'(SLOT_BITS - 1);
  localparam logic [5:0] SLOT1_LAST = 6'(2 * SLOT_BITS - 1);
  localparam logic [5:0] SLOT_LEN = 6'(SLOT_BITS);

  // Register storage
  logic [7:0] iface_q; // Interface setup, bit 5 unused
  logic [7:0] off_lo_q; // Off-time low byte
  logic [7:0] off_hi_q; // Off-time high byte
  logic [7:0] on_q; // On-time byte
  logic [7:0] adc_ref_q; // ADC reference level
  logic [7:0] dac_ref_q; // DAC reference level
  logic [7:0] rd_data_q; // Read answer
  logic [7:0] rd_mux; // Read selection
  logic [7:0] iface_rd; // Interface setup as read

  // Strap capture
  logic [1:0] strap_cnt_q; // Cycles since reset release
  logic strap_done_q; // Strap taken
  logic strap_level_q; // Clock pin level seen at startup
  logic sw_wrote_q; // Software already set the protocol

  // Synchronised pins
  logic [2:0] pins_s; // sck, fsync, sdi after two flops
  logic sck_s; // Synchronised clock pin
  logic fs_s; // Synchronised frame sync
  logic sdi_s; // Synchronised serial data in
  logic sck_d_q; // Previous synchronised clock

  // Master clock generation
  logic [7:0] div_q; // Half period counter
  logic sck_q; // Generated clock level
  logic [5:0] mbit_q; // Master bit position
  logic fs_q; // Generated frame sync
  logic m_rise; // Master clock rising this cycle
  logic m_fall; // Master clock falling this cycle

  // Frame tracking
  logic rise; // Active clock rising
  logic fall; // Active clock falling
  logic fs_last_q; // Frame sync at previous rise
  logic start; // Frame begins with this rise
  logic [5:0] bit_q; // Bit position in frame
  acfg_frame_t frame_q; // Slot state
  logic is_master; // Master role in force
  logic is_short; // Short sync in force

  // Slot datapath
  logic tx_load; // Reload transmit word
  logic tx_bit; // Transmit shifter top bit
  logic [15:0] tx_par; // Transmit shifter contents
  logic [15:0] adc_hold_q; // Latest ADC sample
  logic rx_shift; // Capture a receive bit
  logic rx_last; // Last bit of chosen slot
  logic [15:0] rx_par; // Receive shifter contents
  logic slot_en; // Current slot carries data
  logic out_q; // Output pin data
  logic oe_q; // Output pin enable
  logic [15:0] dac_q; // DAC word
  logic dac_valid_q; // DAC word strobe

  // Decoded configuration
  always_comb
  begin
    iface_cfg.loopback = iface_q[BIT_LOOPBACK];
    iface_cfg.rx_second = iface_q[BIT_RX_SECOND];
    iface_cfg.master = iface_q[BIT_MASTER];
    iface_cfg.output_tristate_idle_slots = iface_q[BIT_TRISTATE];
    iface_cfg.tx_first = iface_q[BIT_TX_FIRST];
    iface_cfg.tx_second = iface_q[BIT_TX_SECOND];
    iface_cfg.short_frame_sync = iface_q[BIT_SHORT_SYNC];
    det_cfg.off_time = {off_hi_q, off_lo_q};
    det_cfg.detector_on_byte = on_q;
    det_cfg.detector_adc_level = adc_ref_q;
    det_cfg.detector_dac_level = dac_ref_q;
  end

  // Interface setup register; reserved bit never stored
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      iface_q <= RST_IFACE & ~(8'h01 << BIT_RESERVED);
    else if (bus_req.wr && bus_req.addr == OFF_IFACE)
      iface_q <= bus_req.wdata & ~(8'h01 << BIT_RESERVED);
    else if (strap_cnt_q == STRAP_WAIT && !strap_done_q && !sw_wrote_q)
      // Low clock pin at startup selects short sync
      iface_q[BIT_SHORT_SYNC] <= ~sck_s;
  end

  // A write before the strap settles is kept, not overwritten
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sw_wrote_q <= 1'b0;
    else if (bus_req.wr && bus_req.addr == OFF_IFACE)
      sw_wrote_q <= 1'b1;
  end

  // Strap capture waits for the synchroniser to fill
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_level_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      if (strap_cnt_q == STRAP_WAIT)
      begin
        strap_done_q <= 1'b1;
        strap_level_q <= sck_s;
      end
      else
        strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // Detector byte registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      off_lo_q <= RST_DET;
      off_hi_q <= RST_DET;
      on_q <= RST_DET;
      adc_ref_q <= RST_DET;
      dac_ref_q <= RST_DET;
    end
    else if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        OFF_OFF_LO: off_lo_q <= bus_req.wdata;
        OFF_OFF_HI: off_hi_q <= bus_req.wdata;
        OFF_ON: on_q <= bus_req.wdata;
        OFF_ADC_REF: adc_ref_q <= bus_req.wdata;
        OFF_DAC_REF: dac_ref_q <= bus_req.wdata;
        // Other offsets ignore writes
        default: ;
      endcase
    end
  end

  // Read selection; unmapped offsets read zero
  always_comb
  begin
    iface_rd = iface_q | (8'h01 << BIT_RESERVED);
    unique case (bus_req.addr)
      OFF_IFACE: rd_mux = iface_rd;
      OFF_OFF_LO: rd_mux = off_lo_q;
      OFF_OFF_HI: rd_mux = off_hi_q;
      OFF_ON: rd_mux = on_q;
      OFF_ADC_REF: rd_mux = adc_ref_q;
      OFF_DAC_REF: rd_mux = dac_ref_q;
      // Block state for software
      OFF_STATUS: rd_mux = {4'h0, strap_level_q, strap_done_q, frame_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_q <= 8'h00;
    else if (bus_req.rd)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= 8'h00;
  end

  assign rd_data = rd_data_q;

  // Pins pass two flops before any logic sees them
  acfg_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({sck_in, fsync_in, sdi_in}),
    .sync_out(pins_s)
  );

  assign sck_s = pins_s[2];
  assign fs_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // Short sync is a slave-only option; master forces long
  assign is_master = iface_q[BIT_MASTER];
  assign is_short = iface_q[BIT_SHORT_SYNC] & ~is_master;

  // Master divider and frame counter
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= 8'h00;
      sck_q <= 1'b0;
      mbit_q <= 6'h00;
      fs_q <= 1'b0;
    end
    else if (!is_master)
    begin
      // Idle generator restarts cleanly on role change
      div_q <= 8'h00;
      sck_q <= 1'b0;
      mbit_q <= FRAME_LAST;
      fs_q <= 1'b0;
    end
    else if (div_q == HALF_DIV_M1)
    begin
      div_q <= 8'h00;
      sck_q <= ~sck_q;
      if (!sck_q)
      begin
        // Long sync high through the first slot
        mbit_q <= (mbit_q == FRAME_LAST) ? 6'h00 : mbit_q + 6'h01;
        fs_q <= (mbit_q == FRAME_LAST) || (mbit_q < SLOT0_LAST);
      end
    end
    else
      div_q <= div_q + 8'h01;
  end

  assign m_rise = is_master && div_q == HALF_DIV_M1 && !sck_q;
  assign m_fall = is_master && div_q == HALF_DIV_M1 && sck_q;

  // Clock and sync pins driven only in master role
  assign sck_out = sck_q;
  assign sck_oe = is_master;
  assign fsync_out = fs_q;
  assign fsync_oe = is_master;

  // Slave edge detect works on the second flop only
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sck_d_q <= 1'b0;
    else
      sck_d_q <= sck_s;
  end

  assign rise = is_master ? m_rise : (sck_s & ~sck_d_q);
  assign fall = is_master ? m_fall : (~sck_s & sck_d_q);

  // Frame start: long on the sync's first bit, short one bit after
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      fs_last_q <= 1'b0;
    else if (rise)
      fs_last_q <= fs_s;
  end

  always_comb
  begin
    if (is_master)
      start = m_rise && mbit_q == FRAME_LAST;
    else if (is_short)
      start = rise && fs_last_q && !fs_s;
    else
      start = rise && fs_s && !fs_last_q;
  end

  // Bit position and slot state
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_q <= 6'h00;
      frame_q <= FR_IDLE;
    end
    else if (start)
    begin
      bit_q <= 6'h00;
      frame_q <= FR_SLOT0;
    end
    else if (rise)
    begin
      unique case (frame_q)
        FR_IDLE: bit_q <= bit_q;
        FR_SLOT0:
        begin
          bit_q <= bit_q + 6'h01;
          if (bit_q == SLOT0_LAST)
            frame_q <= FR_SLOT1;
        end
        FR_SLOT1:
        begin
          bit_q <= bit_q + 6'h01;
          if (bit_q == SLOT1_LAST)
            frame_q <= FR_IDLE;
        end
        // Unused code recovers to idle
        default: frame_q <= FR_IDLE;
      endcase
    end
  end

  // Hold the newest ADC word for transmission
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      adc_hold_q <= 16'h0000;
    else if (adc_valid)
      adc_hold_q <= adc_sample;
  end

  // Same sample goes out in either enabled slot
  assign tx_load = start || (rise && frame_q == FR_SLOT0 &&
                             bit_q == SLOT0_LAST);

  acfg_slot_shift #(
    .WIDTH(SLOT_BITS)
  ) u_tx_shift (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(tx_load),
    .load_data(adc_hold_q),
    .shift_en(rise),
    .serial_in(1'b0),
    .serial_out(tx_bit),
    .par_out(tx_par)
  );

  // Slot carries data only when its enable is set
  always_comb
  begin
    unique case (frame_q)
      FR_SLOT0: slot_en = iface_q[BIT_TX_FIRST];
      FR_SLOT1: slot_en = iface_q[BIT_TX_SECOND];
      default: slot_en = 1'b0;
    endcase
  end

  // Output data and enable from flops; disabled slots send zero
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      out_q <= tx_bit & slot_en;
      if (!iface_q[BIT_TRISTATE])
        oe_q <= 1'b1;
      else
        oe_q <= slot_en;
    end
  end

  assign serial_audio_out_pin = out_q;
  assign serial_audio_out_pin_oe = oe_q;

  // Receive only in the selected slot, sampled on the falling edge
  assign rx_shift = fall && (iface_q[BIT_RX_SECOND] ?
                             frame_q == FR_SLOT1 :
                             frame_q == FR_SLOT0);
  assign rx_last = rx_shift && (bit_q == SLOT0_LAST ||
                                bit_q == SLOT1_LAST);

  acfg_slot_shift #(
    .WIDTH(SLOT_BITS)
  ) u_rx_shift (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(1'b0),
    .load_data(16'h0000),
    .shift_en(rx_shift),
    .serial_in(sdi_s),
    .serial_out(),
    .par_out(rx_par)
  );

  // DAC feed: received word, or ADC word in loopback
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_q <= 16'h0000;
      dac_valid_q <= 1'b0;
    end
    else if (iface_q[BIT_LOOPBACK])
    begin
      dac_valid_q <= adc_valid;
      if (adc_valid)
        dac_q <= adc_sample;
    end
    else
    begin
      dac_valid_q <= rx_last;
      if (rx_last)
        dac_q <= {rx_par[14:0], sdi_s};
    end
  end

  assign dac_sample = dac_q;
  assign dac_valid = dac_valid_q;

  // Slot length is the frame's unit; checked against frame size above
  logic unused_ok;
  assign unused_ok = ^{tx_par, SLOT_LEN};

endmodule
`default_nettype wire

// >>> acfg_pkg.sv
// Shared constants and types of the audio port configuration block
package acfg_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_IFACE = 8'h09;
  localparam logic [7:0] OFF_OFF_LO = 8'h0B;
  localparam logic [7:0] OFF_OFF_HI = 8'h0C;
  localparam logic [7:0] OFF_ON = 8'h0D;
  localparam logic [7:0] OFF_ADC_REF = 8'h0E;
  localparam logic [7:0] OFF_DAC_REF = 8'h0F;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions of the interface setup register
  localparam int BIT_LOOPBACK = 7;
  localparam int BIT_RX_SECOND = 6;
  localparam int BIT_RESERVED = 5;
  localparam int BIT_MASTER = 4;
  localparam int BIT_TRISTATE = 3;
  localparam int BIT_TX_FIRST = 2;
  localparam int BIT_TX_SECOND = 1;
  localparam int BIT_SHORT_SYNC = 0;

  // Field positions of the status register
  localparam int ST_FRAME_LO = 0;
  localparam int ST_STRAP_DONE = 2;
  localparam int ST_STRAP_LEVEL = 3;

  // Reset values
  localparam logic [7:0] RST_IFACE = 8'h24;
  localparam logic [7:0] RST_DET = 8'h00;

  // Timing counts
  localparam int SLOT_BITS = 16;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } acfg_bus_req_t;

  // Decoded interface setup
  typedef struct packed {
    logic loopback;
    logic rx_second;
    logic master;
    logic output_tristate_idle_slots;
    logic tx_first;
    logic tx_second;
    logic short_frame_sync;
  } acfg_iface_cfg_t;

  // Activity detector settings
  typedef struct packed {
    logic [15:0] off_time;
    logic [7:0] detector_on_byte;
    logic [7:0] detector_adc_level;
    logic [7:0] detector_dac_level;
  } acfg_det_cfg_t;

  // Frame position, Gray along idle, slot 0, slot 1
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SLOT0 = 2'b01,
    FR_SLOT1 = 2'b11
  } acfg_frame_t;

endpackage

// >>> acfg_sync.sv
// Two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module acfg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Width must be at least one bit
  initial
  begin
    if (WIDTH < 1)
      $error("acfg_sync: WIDTH below 1");
  end

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic meta_q; // First stage, may go metastable
      logic hold_q; // Second stage, safe to read
      // Each bit owns its flops, so no vector has two writers
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_q <= 1'b0;
          hold_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_in[i];
          hold_q <= meta_q;
        end
      end
      assign sync_out[i] = hold_q;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> acfg_slot_shift.sv
// Shift register for one audio slot, MSB first
`timescale 1ns/1ps
`default_nettype none
module acfg_slot_shift #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic shift_en,
  input wire logic serial_in,
  output logic serial_out,
  output logic [WIDTH-1:0] par_out
);

  // Need room for a shift
  initial
  begin
    if (WIDTH < 2)
      $error("acfg_slot_shift: WIDTH below 2");
  end

  // Load wins over shift
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      par_out <= '0;
    else if (load)
      par_out <= load_data;
    else if (shift_en)
      par_out <= {par_out[WIDTH-2:0], serial_in};
  end

  // Bit on the wire is the top bit
  assign serial_out = par_out[WIDTH-1];

endmodule
`default_nettype wire

// >>> acfg_top_asserts.sv
// Concurrent checks on the audio port configuration block ports
`timescale 1ns/1ps
`default_nettype none
module acfg_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire acfg_pkg::acfg_bus_req_t bus_req,
  input wire logic [acfg_pkg::DATA_W-1:0] rd_data,
  input wire logic sck_oe,
  input wire logic fsync_oe,
  input wire logic serial_audio_out_pin_oe,
  input wire logic [15:0] adc_sample,
  input wire logic adc_valid,
  input wire logic [15:0] dac_sample,
  input wire logic dac_valid,
  input wire acfg_pkg::acfg_iface_cfg_t iface_cfg,
  input wire acfg_pkg::acfg_det_cfg_t det_cfg
);
  import acfg_pkg::*;
  // One clock domain; reset cancels every attempt
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  off_low_a: assert property (
    bus_req.wr && bus_req.addr == OFF_OFF_LO |=>
    det_cfg.off_time[7:0] == $past(bus_req.wdata))
    else $error("off-time low byte not taken");
  off_high_a: assert property (
    bus_req.wr && bus_req.addr == OFF_OFF_HI |=>
    det_cfg.off_time[15:8] == $past(bus_req.wdata))
    else $error("off-time high byte not taken");
  adc_level_a: assert property (
    bus_req.wr && bus_req.addr == OFF_ADC_REF |=>
    det_cfg.detector_adc_level == $past(bus_req.wdata))
    else $error("adc level not taken");
  dac_level_a: assert property (
    bus_req.wr && bus_req.addr == OFF_DAC_REF |=>
    det_cfg.detector_dac_level == $past(bus_req.wdata))
    else $error("dac level not taken");
  on_read_a: assert property (
    bus_req.rd && bus_req.addr == OFF_ON |=>
    rd_data == $past(det_cfg.detector_on_byte))
    else $error("on-time readback wrong");
  reserved_one_a: assert property (
    bus_req.rd && bus_req.addr == OFF_IFACE |=> rd_data[5])
    else $error("reserved setup bit not one");
  loop_route_a: assert property (
    iface_cfg.loopback && adc_valid |=>
    dac_valid && dac_sample == $past(adc_sample))
    else $error("loopback word not routed");
  master_drive_a: assert property (
    iface_cfg.master [*2] |-> sck_oe && fsync_oe)
    else $error("master role not driving clocks");
  oe_steady_a: assert property (
    (!iface_cfg.output_tristate_idle_slots && $past(rst_b)) [*2] |->
    serial_audio_out_pin_oe)
    else $error("output released with tristate off");
  slots_quiet_a: assert property (
    (iface_cfg.output_tristate_idle_slots && !iface_cfg.tx_first &&
    !iface_cfg.tx_second) [*2] |-> !serial_audio_out_pin_oe)
    else $error("output driven with no slot enabled");
endmodule
bind acfg_top acfg_checker u_acfg_checker (.core_clk(core_clk),
  .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data), .sck_oe(sck_oe),
  .fsync_oe(fsync_oe), .serial_audio_out_pin_oe(serial_audio_out_pin_oe),
  .adc_sample(adc_sample), .adc_valid(adc_valid), .dac_sample(dac_sample),
  .dac_valid(dac_valid), .iface_cfg(iface_cfg), .det_cfg(det_cfg));
`default_nettype wire

// >>> acfg_testbench.sv
// Self-checking bench for the audio port configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acfg_pkg::*;
  localparam int HALF = 4;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  acfg_bus_req_t bus_req = '0;
  logic sck_in = 1'b0;
  logic fsync_in = 1'b0;
  logic sdi_in = 1'b0;
  logic [15:0] adc_sample = '0;
  logic adc_valid = 1'b0;
  logic [7:0] rd_data;
  logic sck_out, sck_oe, fsync_out, fsync_oe, pin, pin_oe, dac_valid;
  logic [15:0] dac_sample, rx_seen;
  acfg_iface_cfg_t iface_cfg;
  acfg_det_cfg_t det_cfg;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int rx_cnt = 0;
  logic [7:0] shadow [5];
  // Free-running core clock, 10 ns
  always #5 core_clk = ~core_clk;
  acfg_top #(.MASTER_HALF_DIV(HALF), .FRAME_BITS(32)) u_acfg_top (
    .core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .fsync_in(fsync_in), .fsync_out(fsync_out),
    .fsync_oe(fsync_oe), .sdi_in(sdi_in), .serial_audio_out_pin(pin),
    .serial_audio_out_pin_oe(pin_oe), .adc_sample(adc_sample),
    .adc_valid(adc_valid), .dac_sample(dac_sample),
    .dac_valid(dac_valid), .iface_cfg(iface_cfg), .det_cfg(det_cfg));
  // Last received word; pulse is only one cycle wide
  always @(posedge core_clk)
    if (dac_valid === 1'b1)
    begin
      rx_seen <= dac_sample;
      rx_cnt <= rx_cnt + 1;
    end
  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Bus tasks start just after an edge and end on one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
    input string what);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    chk(what, rd_data, exp);
    @(posedge core_clk);
  endtask
  // Strap level must stay put until the capture is over
  task automatic do_reset(input logic strap);
    rst_b <= 1'b0;
    sck_in <= strap;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic adc_word(input logic [15:0] w);
    adc_sample <= w;
    adc_valid <= 1'b1;
    @(posedge core_clk);
    adc_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  // Slave frame, long or short sync by c[0], ten core cycles per bit, two lead-in bits
  task automatic frame(input logic [7:0] c, input logic [15:0] tx,
    input logic [15:0] rx);
    logic en;
    int b;
    int k;
    int got0;
    got0 = rx_cnt;
    for (k = -2; k < 34; k++)
    begin
      b = (k < 0) ? 0 : k % 16;
      en = (k < 0 || k > 31) ? 1'b0 : (k < 16 ? c[2] : c[1]);
      sck_in <= 1'b1;
      // Short sync pulses one bit ahead of the frame
      fsync_in <= c[0] ? (k == -1) : (k >= 0 && k < 16);
      // Unselected slot carries the inverse, so a wrong pick shows
      sdi_in <= ((k >= 16) == c[6]) ? rx[15-b] : ~rx[15-b];
      repeat (5) @(posedge core_clk);
      sck_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      if (k >= 0)
      begin
        chk("data_oe", pin_oe, c[3] ? en : 1'b1);
        if (k < 32 && pin_oe === 1'b1)
          chk("data_bit", pin, en ? tx[15-b] : 1'b0);
      end
      @(posedge core_clk);
    end
    chk("rx_count", rx_cnt - got0, 1);
    chk("rx_word", rx_seen, rx);
  endtask
  initial
  begin
    logic [7:0] v;
    logic [15:0] w;
    logic prev;
    int n;
    n = $urandom(28);
    do_reset(1'b0);
    rdc(OFF_IFACE, 8'h25, "setup_low_strap");
    rdc(OFF_STATUS, 8'h04, "status_low_strap");
    chk("decode_reset", iface_cfg, 7'h05);
    for (int i = 0; i < 5; i++)
      rdc(8'(OFF_OFF_LO + i), 8'h00, "det_reset");
    rdc(8'h0A, 8'h00, "unmapped");
    do_reset(1'b1);
    rdc(OFF_IFACE, 8'h24, "setup_high_strap");
    rdc(OFF_STATUS, 8'h0C, "status_high_strap");
    // Corner setups first, then random slot setups
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h08 : (i == 1) ? 8'h46 : (i == 2) ? 8'h0D :
        8'($urandom) & 8'h4F;
      wr(OFF_IFACE, v);
      w = 16'($urandom);
      adc_word(w);
      frame(v, w, 16'($urandom));
    end
    repeat (4)
    begin
      for (int i = 0; i < 5; i++)
      begin
        shadow[i] = 8'($urandom);
        wr(8'(OFF_OFF_LO + i), shadow[i]);
      end
      for (int i = 0; i < 5; i++)
        rdc(8'(OFF_OFF_LO + i), shadow[i], "det_byte");
      chk("off_time", det_cfg.off_time, {shadow[1], shadow[0]});
      chk("levels", {det_cfg.detector_on_byte, det_cfg.detector_adc_level,
        det_cfg.detector_dac_level}, {shadow[2], shadow[3], shadow[4]});
      v = 8'($urandom);
      wr(OFF_IFACE, v);
      rdc(OFF_IFACE, v | 8'h20, "setup_rb");
      chk("decode", iface_cfg, {v[7:6], v[4:0]});
    end
    for (int lb = 1; lb >= 0; lb--)
    begin
      wr(OFF_IFACE, lb[0] ? 8'h80 : 8'h04);
      w = 16'($urandom);
      // Strobe the word and look while the answer stands
      adc_sample <= w;
      adc_valid <= 1'b1;
      @(posedge core_clk);
      adc_valid <= 1'b0;
      #1;
      chk("loop_valid", dac_valid, lb[0]);
      if (lb == 1)
        chk("loop_word", dac_sample, w);
      @(posedge core_clk);
    end
    // Master with short sync asked for; clock still generated
    wr(OFF_IFACE, 8'h15);
    repeat (10) @(posedge core_clk);
    #1;
    prev = sck_out;
    n = 0;
    repeat (8 * HALF)
    begin
      @(posedge core_clk);
      #1;
      if (sck_out !== prev)
        n++;
      prev = sck_out;
    end
    chk("master_toggles", n, 8);
    chk("master_oe", {sck_oe, fsync_oe}, 2'b11);
    // Long sync high for one slot of every two-slot frame
    n = 0;
    repeat (4 * SLOT_BITS * HALF)
    begin
      @(posedge core_clk);
      #1;
      if (fsync_out === 1'b1)
        n++;
    end
    chk("master_sync", n, 2 * SLOT_BITS * HALF);
    @(posedge core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
